// ==== rtl/ddrg_rx_gearbox.sv ====
/*
 Geared DDR receive front end with x2, x4 and x5 gearing, centered and
 edge-aligned clocking, data delay taps, clock delay loop and startup sequencer.
 Assumes pad dual-edge flops deliver one rise and one fall bit per lane per CLK,
 CLK standing for the fast edge clock, and an APB master on the same clock.
*/
// The register offsets and the APB slave port were left to the implementer.
module ddrg_rx_gearbox #(
	parameter int LANES = 4
) (
	input  wire logic                     CLK,
	input  wire logic                     RESET_N,
	input  wire logic                     PSEL,
	input  wire logic                     PENABLE,
	input  wire logic                     PWRITE,
	input  wire logic [7:0]               PADDR,
	input  wire logic [31:0]              PWDATA,
	output logic      [31:0]              PRDATA,
	output logic                          PREADY,
	output logic                          PSLVERR,
	input  wire logic [LANES-1:0]         DATA_RISE,
	input  wire logic [LANES-1:0]         DATA_FALL,
	output logic                          FAST_CLK_EN,
	output logic                          SLOW_CLK,
	output logic                          CAPTURE_RST,
	output logic [LANES*ddrg_pkg::WORD_W-1:0] RX_WORD,
	output logic                          RX_VALID
);

	if (LANES < 1 || LANES > 32) begin : g_check
		$error("LANES must lie between 1 and 32");
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	ddrg_pkg::ddrg_ctrl_t  ctrl_q, ctrl_d, cfg_q, cfg_d;
	ddrg_pkg::ddrg_state_t state_q, state_d;
	logic [2:0]  delay_q, delay_d, utap_q, utap_d, slave_q, slave_d, dll_q, dll_d;
	logic [3:0]  margin_q, margin_d;
	logic        err_q, err_d, freeze_q, freeze_d, gate_q, gate_d, rst_q, rst_d;
	logic [31:0] prdata_q, prdata_d;
	logic [6:0]  timer_q, timer_d, lock_q, lock_d;
	logic [2:0]  cnt_q, cnt_d, ratio;
	logic        slow_q, slow_d, valid_q, valid_d, locked, refused, wr, mapped;
	logic [4:0]  trim_sum;

	assign wr      = PSEL && PENABLE && PWRITE;
	assign mapped  = PADDR == ddrg_pkg::ADDR_CTRL || PADDR == ddrg_pkg::ADDR_DELAY
		|| PADDR == ddrg_pkg::ADDR_MARGIN || PADDR == ddrg_pkg::ADDR_STATUS;
	assign PREADY  = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA  = prdata_q;
	// A bad gear code is refused along with a slow link
	assign refused = state_q == ddrg_pkg::S_IDLE && ctrl_q.enable
		&& (!ctrl_q.fast_link || ctrl_q.gear == ddrg_pkg::GEAR_BAD);

	always_comb begin
		ctrl_d   = ctrl_q;
		delay_d  = delay_q;
		margin_d = margin_q;
		prdata_d = prdata_q;
		if (wr && PADDR == ddrg_pkg::ADDR_CTRL) begin
			ctrl_d = ddrg_pkg::ddrg_ctrl_t'(PWDATA[ddrg_pkg::CTRL_W-1:0]);
		end
		if (wr && PADDR == ddrg_pkg::ADDR_DELAY) begin
			delay_d = PWDATA[2:0];
		end
		if (wr && PADDR == ddrg_pkg::ADDR_MARGIN) begin
			margin_d = PWDATA[3:0];
		end
		// Set wins over a clear landing in the same cycle
		if (refused) begin
			err_d = 1'b1;
		end else if (wr && PADDR == ddrg_pkg::ADDR_STATUS && PWDATA[ddrg_pkg::ST_ERR]) begin
			err_d = 1'b0;
		end else begin
			err_d = err_q;
		end
		if (PSEL && !PENABLE && !PWRITE) begin
			prdata_d = 32'h0000_0000;
			unique case (PADDR)
				ddrg_pkg::ADDR_CTRL:   prdata_d[ddrg_pkg::CTRL_W-1:0] = ctrl_q;
				ddrg_pkg::ADDR_DELAY:  prdata_d[2:0] = delay_q;
				ddrg_pkg::ADDR_MARGIN: prdata_d[3:0] = margin_q;
				ddrg_pkg::ADDR_STATUS: begin
					prdata_d[ddrg_pkg::ST_RUN]    = gate_q;
					prdata_d[ddrg_pkg::ST_LOCK]   = locked;
					prdata_d[ddrg_pkg::ST_FREEZE] = freeze_q;
					prdata_d[ddrg_pkg::ST_ERR]    = err_q;
					prdata_d[ddrg_pkg::ST_STATE +: 3] = state_q;
					prdata_d[ddrg_pkg::ST_CODE +: 3]  = slave_q;
				end
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ctrl_q   <= ddrg_pkg::CTRL_RST;
			delay_q  <= ddrg_pkg::DELAY_RST;
			margin_q <= ddrg_pkg::MARGIN_RST;
			err_q    <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			ctrl_q   <= ctrl_d;
			delay_q  <= delay_d;
			margin_q <= margin_d;
			err_q    <= err_d;
			prdata_q <= prdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Startup sequencer and clock delay loop
	// ----------------------------------------------------------------
	assign locked   = lock_q == 7'(ddrg_pkg::LOCK_CYCLES - 1);
	// Trim is taken around the base code, not the last code, so it cannot creep
	assign trim_sum = 5'({2'b00, ddrg_pkg::DLL_BASE}) + 5'({margin_q[3], margin_q});

	always_comb begin
		state_d = state_q;
		cfg_d   = cfg_q;
		utap_d  = utap_q;
		timer_d = timer_q + 7'h01;
		unique case (state_q)
			ddrg_pkg::S_IDLE: begin
				timer_d = 7'h00;
				if (ctrl_q.enable && !refused) begin
					cfg_d   = ctrl_q;
					utap_d  = delay_q;
					state_d = ddrg_pkg::S_STOP;
				end
			end
			ddrg_pkg::S_STOP: if (timer_q == 7'(ddrg_pkg::STOP_CYCLES - 1)) begin
				timer_d = 7'h00;
				state_d = cfg_q.aligned ? ddrg_pkg::S_WLOCK : ddrg_pkg::S_REL;
			end
			ddrg_pkg::S_WLOCK: if (locked) begin
				state_d = ddrg_pkg::S_LOAD;
			end
			ddrg_pkg::S_LOAD: begin
				timer_d = 7'h00;
				state_d = ddrg_pkg::S_REL;
			end
			ddrg_pkg::S_REL: if (timer_q == 7'(ddrg_pkg::REL_CYCLES - 1)) begin
				state_d = ddrg_pkg::S_RUN;
			end
			ddrg_pkg::S_RUN: timer_d = 7'h00;
			default: state_d = ddrg_pkg::S_IDLE;
		endcase
		if (state_q != ddrg_pkg::S_IDLE && !ctrl_q.enable) begin
			state_d = ddrg_pkg::S_IDLE;
		end
		gate_d   = state_d == ddrg_pkg::S_RUN;
		rst_d    = !(state_d == ddrg_pkg::S_REL || state_d == ddrg_pkg::S_RUN);
		freeze_d = cfg_d.aligned && (state_d == ddrg_pkg::S_STOP
			|| state_d == ddrg_pkg::S_WLOCK || state_d == ddrg_pkg::S_LOAD);
		// Frozen master holds its code; free master follows base plus trim, clamped
		if (state_d == ddrg_pkg::S_IDLE) begin
			dll_d = ddrg_pkg::DLL_BASE;
		end else if (freeze_d) begin
			dll_d = dll_q;
		end else if (trim_sum[4]) begin
			dll_d = 3'h0;
		end else if (trim_sum[3]) begin
			dll_d = 3'h7;
		end else begin
			dll_d = trim_sum[2:0];
		end
		// Slave follows only after lock; centered mode keeps it at zero shift
		if (!cfg_q.aligned || state_q == ddrg_pkg::S_IDLE) begin
			slave_d = 3'h0;
		end else if (state_q == ddrg_pkg::S_LOAD || state_q == ddrg_pkg::S_REL
			|| state_q == ddrg_pkg::S_RUN) begin
			slave_d = dll_q;
		end else begin
			slave_d = slave_q;
		end
		// Master is clocked by the slave output: a moved slave phase restarts lock
		if (!cfg_q.aligned || state_q == ddrg_pkg::S_IDLE || slave_d != slave_q) begin
			lock_d = 7'h00;
		end else if (locked) begin
			lock_d = lock_q;
		end else begin
			lock_d = lock_q + 7'h01;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state_q  <= ddrg_pkg::S_IDLE;
			cfg_q    <= ddrg_pkg::CTRL_RST;
			utap_q   <= ddrg_pkg::DELAY_RST;
			timer_q  <= 7'h00;
			gate_q   <= 1'b0;
			rst_q    <= 1'b1;
			freeze_q <= 1'b0;
			dll_q    <= ddrg_pkg::DLL_BASE;
			slave_q  <= 3'h0;
			lock_q   <= 7'h00;
		end else begin
			state_q  <= state_d;
			cfg_q    <= cfg_d;
			utap_q   <= utap_d;
			timer_q  <= timer_d;
			gate_q   <= gate_d;
			rst_q    <= rst_d;
			freeze_q <= freeze_d;
			dll_q    <= dll_d;
			slave_q  <= slave_d;
			lock_q   <= lock_d;
		end
	end

	// ----------------------------------------------------------------
	// Divider and word timing, shared by all lanes
	// ----------------------------------------------------------------
	always_comb begin
		unique case (cfg_q.gear)
			ddrg_pkg::GEAR_X2: ratio = 3'd2;
			ddrg_pkg::GEAR_X4: ratio = 3'd4;
			default:           ratio = 3'd5;
		endcase
		cnt_d   = cnt_q;
		valid_d = 1'b0;
		if (rst_q) begin
			cnt_d = 3'd0;
		end else if (gate_q) begin
			valid_d = cnt_q == ratio - 3'd1;
			cnt_d   = valid_d ? 3'd0 : cnt_q + 3'd1;
		end
		// Divider halts with the gate; odd ratios give a shorter high phase
		slow_d = !rst_q && gate_q ? cnt_d < (ratio >> 1) : slow_q;
		if (rst_q) begin
			slow_d = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			cnt_q   <= 3'd0;
			valid_q <= 1'b0;
			slow_q  <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			valid_q <= valid_d;
			slow_q  <= slow_d;
		end
	end

	assign FAST_CLK_EN = gate_q;
	assign SLOW_CLK    = slow_q;
	assign CAPTURE_RST = rst_q;
	assign RX_VALID    = valid_q;

	// ----------------------------------------------------------------
	// Per-lane sync, data delay and capture
	// ----------------------------------------------------------------
	logic [2:0] data_tap;
	logic [3:0] tap_sel;

	assign data_tap = cfg_q.dyn_delay ? delay_q
		: (cfg_q.user_kind ? utap_q : ddrg_pkg::DEF_TAP_ZH);
	// Shifting the clock later is the same as sampling deeper into the line
	assign tap_sel = {1'b0, data_tap} + {1'b0, slave_q};

	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [1:0] meta_q, sync_q, pair;
		logic [1:0] dl_q [ddrg_pkg::DLY_DEPTH];
		logic [1:0] dl_d [ddrg_pkg::DLY_DEPTH];
		logic [ddrg_pkg::WORD_W-1:0] sh_q, sh_d, word_q, word_d;

		assign pair = dl_q[tap_sel];

		always_comb begin
			dl_d[0] = sync_q;
			for (int i = 1; i < ddrg_pkg::DLY_DEPTH; i++) begin
				dl_d[i] = dl_q[i-1];
			end
			sh_d   = sh_q;
			word_d = word_q;
			if (rst_q) begin
				sh_d = '0;
			end else if (gate_q) begin
				sh_d[{cnt_q, 1'b0}]        = pair[0];
				sh_d[{cnt_q, 1'b0} + 4'd1] = pair[1];
				if (valid_d) begin
					word_d = sh_d;
					sh_d   = '0;
				end
			end
		end

		always_ff @(posedge CLK) begin
			if (!RESET_N) begin
				meta_q <= 2'b00;
				sync_q <= 2'b00;
				sh_q   <= '0;
				word_q <= '0;
				for (int i = 0; i < ddrg_pkg::DLY_DEPTH; i++) begin
					dl_q[i] <= 2'b00;
				end
			end else begin
				meta_q <= {DATA_FALL[l], DATA_RISE[l]};
				sync_q <= meta_q;
				sh_q   <= sh_d;
				word_q <= word_d;
				dl_q   <= dl_d;
			end
		end

		assign RX_WORD[l*ddrg_pkg::WORD_W +: ddrg_pkg::WORD_W] = word_q;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_rate_gate;
		@(posedge CLK) disable iff (!RESET_N)
		(state_q == ddrg_pkg::S_IDLE && state_d != ddrg_pkg::S_IDLE) |-> ctrl_q.fast_link;
	endproperty
	a_rate_gate: assert property (p_rate_gate) else $error("start without fast link");

	property p_x2_period;
		@(posedge CLK) disable iff (!RESET_N)
		(RX_VALID && gate_q && cfg_q.gear == ddrg_pkg::GEAR_X2) |=>
			!RX_VALID ##1 (RX_VALID || !gate_q);
	endproperty
	a_x2_period: assert property (p_x2_period) else $error("x2 word period wrong");

	property p_x4_period;
		@(posedge CLK) disable iff (!RESET_N)
		(RX_VALID && gate_q && cfg_q.gear == ddrg_pkg::GEAR_X4) |=>
			!RX_VALID [*3] ##1 (RX_VALID || !gate_q);
	endproperty
	a_x4_period: assert property (p_x4_period) else $error("x4 word period wrong");

	property p_x5_period;
		@(posedge CLK) disable iff (!RESET_N)
		(RX_VALID && gate_q && cfg_q.gear == ddrg_pkg::GEAR_X5) |=>
			!RX_VALID [*4] ##1 (RX_VALID || !gate_q);
	endproperty
	a_x5_period: assert property (p_x5_period) else $error("x5 word period wrong");

	property p_center_noshift;
		@(posedge CLK) disable iff (!RESET_N)
		(FAST_CLK_EN && !cfg_q.aligned) |-> slave_q == 3'h0 && state_q == ddrg_pkg::S_RUN;
	endproperty
	a_center_noshift: assert property (p_center_noshift) else $error("centered clock shifted");

	property p_default_tap;
		@(posedge CLK) disable iff (!RESET_N)
		(!cfg_q.dyn_delay && !cfg_q.user_kind) |-> data_tap == ddrg_pkg::DEF_TAP_ZH;
	endproperty
	a_default_tap: assert property (p_default_tap) else $error("default tap wrong");

	property p_dyn_tap;
		@(posedge CLK) disable iff (!RESET_N)
		(cfg_q.dyn_delay && wr && PADDR == ddrg_pkg::ADDR_DELAY) |=> data_tap == $past(PWDATA[2:0]);
	endproperty
	a_dyn_tap: assert property (p_dyn_tap) else $error("adjustable tap not applied");

	property p_no_update_unlocked;
		@(posedge CLK) disable iff (!RESET_N)
		(state_q == ddrg_pkg::S_WLOCK) |=> $stable(slave_q);
	endproperty
	a_no_update_unlocked: assert property (p_no_update_unlocked) else $error("slave moved early");

	property p_load_then_thaw;
		@(posedge CLK) disable iff (!RESET_N)
		(state_q == ddrg_pkg::S_LOAD && ctrl_q.enable) |->
			freeze_q ##1 (!freeze_q && slave_q == $past(dll_q));
	endproperty
	a_load_then_thaw: assert property (p_load_then_thaw) else $error("load and thaw out of order");

	property p_gate_after_reset;
		@(posedge CLK) disable iff (!RESET_N)
		$rose(FAST_CLK_EN) |-> !CAPTURE_RST && !$past(CAPTURE_RST, 2) && !$past(FAST_CLK_EN, 2);
	endproperty
	a_gate_after_reset: assert property (p_gate_after_reset) else $error("gate opened in reset");

	property p_slow_stops;
		@(posedge CLK) disable iff (!RESET_N)
		!FAST_CLK_EN |=> (!SLOW_CLK || FAST_CLK_EN);
	endproperty
	a_slow_stops: assert property (p_slow_stops) else $error("slow clock ran while stopped");

endmodule

// ==== include/ddrg_pkg.sv ====
/*
 Shared constants and types of the geared DDR receive front end: register map,
 control layout, reset values, sequencer states and startup timing counts.
 Assumes a 50 MHz register clock and a 32-bit APB slave port.
*/
package ddrg_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_DELAY  = 8'h04;
	localparam logic [7:0] ADDR_MARGIN = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GEAR_X2 = 2'b00,
		GEAR_X4 = 2'b01,
		GEAR_X5 = 2'b10,
		GEAR_BAD = 2'b11
	} ddrg_gear_t;

	typedef struct packed {
		logic       fast_link;
		logic       user_kind;
		logic       dyn_delay;
		logic       aligned;
		ddrg_gear_t gear;
		logic       enable;
	} ddrg_ctrl_t;

	localparam int         CTRL_W      = 7;
	localparam ddrg_ctrl_t CTRL_RST    = ddrg_ctrl_t'(7'h00);
	localparam logic [2:0] DELAY_RST   = 3'h0;
	localparam logic [3:0] MARGIN_RST  = 4'h0;
	localparam int         ST_RUN      = 0;
	localparam int         ST_LOCK     = 1;
	localparam int         ST_FREEZE   = 2;
	localparam int         ST_ERR      = 3;
	localparam int         ST_STATE    = 4;
	localparam int         ST_CODE     = 8;
	localparam int         WORD_W      = 10;
	localparam int         DLY_DEPTH   = 16;
	localparam logic [2:0] DEF_TAP_ZH  = 3'h2;
	localparam logic [2:0] DLL_BASE    = 3'h4;

	// ----------------------------------------------------------------
	// Startup sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_STOP  = 3'b001,
		S_WLOCK = 3'b010,
		S_LOAD  = 3'b011,
		S_REL   = 3'b100,
		S_RUN   = 3'b101
	} ddrg_state_t;

	localparam int CLK_PERIOD_NS = 20;
	localparam int STOP_TIME_NS  = 80;
	localparam int REL_TIME_NS   = 160;
	localparam int LOCK_TIME_NS  = 1280;
	localparam int STOP_CYCLES   = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REL_CYCLES    = (REL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== tb/ddrg_tx_model.sv ====
/*
 Far-side transmitter model: puts one rise-edge and one fall-edge bit on every lane
 each fast cycle. It assumes that the bench seeds $urandom before the first edge and
 records what the lanes carry at every rising edge.
*/
module ddrg_tx_model #(
	parameter int LANES = 4
) (
	input  wire logic             clk,
	output logic      [LANES-1:0] rise,
	output logic      [LANES-1:0] fall
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		rise = '0;
		fall = '0;
	end

	// ----------------------------------------------------------------
	// Lane data
	// ----------------------------------------------------------------
	// Fresh random bits every cycle, so a stale value matches a captured one only by chance
	always @(posedge clk) begin
		rise <= LANES'($urandom);
		fall <= LANES'($urandom);
	end
endmodule

// ==== tb/tb_top.sv ====
/*
 Self-checking bench of the geared DDR receive front end: APB registers, refused
 starts, startup ordering, word assembly in every gear, data delay and clock loop.
 It assumes the transmitter model and the design package; one 50 MHz clock.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int L = 4;
	localparam int W = ddrg_pkg::WORD_W;

	logic                  clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rd, v;
	logic [L-1:0]          d_rise, d_fall;
	logic                  fast_en, slow_clk, cap_rst, rx_valid;
	logic [L*W-1:0]        rx_word;
	logic [L-1:0]          hr[$];
	logic [L-1:0]          hf[$];
	logic [3:0]            trim;
	int                    n_errors, n_tests, d0, dl, t, tp;
	logic [7:0]            ra[4] = '{ddrg_pkg::ADDR_CTRL, ddrg_pkg::ADDR_DELAY,
		ddrg_pkg::ADDR_MARGIN, ddrg_pkg::ADDR_STATUS};
	logic [31:0]           rw[4] = '{32'h7F, 32'h7, 32'hF, 32'h0};
	logic [31:0]           bad[2] = '{32'hFFFFFFFF, 32'h1};
	ddrg_pkg::ddrg_gear_t  gr[3] = '{ddrg_pkg::GEAR_X2, ddrg_pkg::GEAR_X4, ddrg_pkg::GEAR_X5};
	int                    gn[3] = '{2, 4, 5};

	ddrg_rx_gearbox #(.LANES(L)) dut (
		.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.DATA_RISE(d_rise), .DATA_FALL(d_fall), .FAST_CLK_EN(fast_en), .SLOW_CLK(slow_clk),
		.CAPTURE_RST(cap_rst), .RX_WORD(rx_word), .RX_VALID(rx_valid)
	);
	ddrg_tx_model #(.LANES(L)) tx (.clk(clk), .rise(d_rise), .fall(d_fall));

	always #10 clk = ~clk;

	// ----------------------------------------------------------------
	// Reference model: lane history and expected words
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		hr.push_back(d_rise);
		hf.push_back(d_fall);
	end

	function automatic logic [W-1:0] expw(input int s, input int g, input int l);
		logic [W-1:0] e;
		e = '0;
		for (int k = 0; k < g; k++) begin
			e[2*k] = hr[s+k][l];
			e[2*k+1] = hf[s+k][l];
		end
		return e;
	endfunction

	function automatic bit hit(input int s, input int g);
		for (int l = 0; l < L; l++)
			if (rx_word[l*W +: W] !== expw(s, g, l))
				return 1'b0;
		return 1'b1;
	endfunction

	function automatic logic [2:0] code_of(input logic [3:0] tr);
		int c;
		c = int'(ddrg_pkg::DLL_BASE) + int'($signed(tr));
		return (c < 0) ? 3'h0 : (c > 7) ? 3'h7 : 3'(c);
	endfunction

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask

	// Counts the cycles of released reset before the gate opens
	task automatic start(input logic [6:0] cfg, output int n);
		int lo;
		apb(1'b1, ddrg_pkg::ADDR_CTRL, {25'h0, cfg});
		n = 0;
		lo = 0;
		while (fast_en !== 1'b1 && n < 400) begin
			tick();
			n++;
			if (cap_rst === 1'b1) begin
				chk(fast_en, 1'b0);
				lo = 0;
			end else if (fast_en !== 1'b1)
				lo++;
		end
		chk(lo, ddrg_pkg::REL_CYCLES);
	endtask

	task automatic stop();
		apb(1'b1, ddrg_pkg::ADDR_CTRL, 32'h0);
		repeat (3) tick();
		chk({fast_en, cap_rst, rx_valid}, 3'b010);
	endtask

	// Skips three words after any change, finds the data delay, then follows six words
	task automatic words(input int g, output int dly);
		int c, last, nw, hi;
		dly = -1;
		nw = 0;
		hi = 0;
		last = 0;
		for (int i = 0; i < 20 * g + 60 && nw < 10; i++) begin
			tick();
			c = hr.size() - 1;
			if (dly >= 0)
				hi += int'(slow_clk === 1'b1);
			if (rx_valid === 1'b1) begin
				nw++;
				if (nw == 4) begin
					for (int d = 0; d < 48 && dly < 0; d++)
						if (hit(c - d - g + 1, g))
							dly = d;
					chk(dly >= 0, 1'b1);
				end else if (nw > 4) begin
					chk(c - last, g);
					for (int l = 0; l < L; l++)
						chk(rx_word[l*W +: W], expw(c - dly - g + 1, g, l));
				end
				last = c;
			end
		end
		chk(nw, 10);
		chk(hi, 6 * (g == 2 ? 1 : 2));
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		n_tests = 0;
		void'($urandom(96279));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		tick();
		chk({fast_en, cap_rst, rx_valid, |rx_word}, 4'b0100);
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			chk(rd & (i == 3 ? 32'h7F : 32'hFFFFFFFF), 32'h0);
			chk(rerr, 1'b0);
		end
		for (int i = 1; i < 3; i++) begin
			v = $urandom;
			apb(1'b1, ra[i], v);
			apb(1'b0, ra[i], 32'h0);
			chk(rd, v & rw[i]);
		end
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		chk(rerr, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk({rerr, rd[30:0]}, 32'h80000000);
		done("registers");
		foreach (bad[i]) begin
			apb(1'b1, ddrg_pkg::ADDR_CTRL, bad[i]);
			repeat (20) tick();
			chk(fast_en, 1'b0);
			apb(1'b0, ddrg_pkg::ADDR_CTRL, 32'h0);
			chk(rd, bad[i] & 32'h7F);
			apb(1'b0, ddrg_pkg::ADDR_STATUS, 32'h0);
			chk(rd[3:0], 4'h8);
			apb(1'b1, ddrg_pkg::ADDR_CTRL, 32'h0);
			apb(1'b1, ddrg_pkg::ADDR_STATUS, 32'h8);
			apb(1'b0, ddrg_pkg::ADDR_STATUS, 32'h0);
			chk(rd[3], 1'b0);
		end
		done("refused start");
		foreach (gr[i]) begin
			start({4'b1000, gr[i], 1'b1}, t);
			words(gn[i], dl);
			if (i == 0)
				d0 = dl;
			stop();
			done("centered gear");
		end
		apb(1'b1, ddrg_pkg::ADDR_DELAY, 32'h5);
		start(7'h61, t);
		apb(1'b1, ddrg_pkg::ADDR_DELAY, 32'h7);
		words(2, dl);
		chk(dl, d0 + 5 - int'(ddrg_pkg::DEF_TAP_ZH));
		stop();
		start(7'h71, t);
		tp = $urandom % 8;
		apb(1'b1, ddrg_pkg::ADDR_DELAY, 32'(tp));
		words(2, dl);
		chk(dl, d0 + tp - int'(ddrg_pkg::DEF_TAP_ZH));
		stop();
		done("data delay");
		trim = 4'($urandom);
		apb(1'b1, ddrg_pkg::ADDR_MARGIN, {28'h0, trim});
		start(7'h49, t);
		chk(t > ddrg_pkg::LOCK_CYCLES, 1'b1);
		apb(1'b0, ddrg_pkg::ADDR_STATUS, 32'h0);
		// Slave has just taken its code, so the loop is still relocking here
		chk(rd[3:0], 4'h1);
		chk(rd[10:8], code_of(trim));
		words(2, dl);
		chk(dl, d0 + int'(code_of(trim)));
		trim = 4'($urandom);
		apb(1'b1, ddrg_pkg::ADDR_MARGIN, {28'h0, trim});
		t = 0;
		do begin
			apb(1'b0, ddrg_pkg::ADDR_STATUS, 32'h0);
			t++;
		end while ((rd[10:8] !== code_of(trim) || rd[1] !== 1'b1) && t < 60);
		chk(rd[10:8], code_of(trim));
		chk(rd[2:0], 3'h3);
		stop();
		done("edge aligned");
		wrap_up();
	end

	initial begin
		#400000;
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule
